// File: include/serial_bus_pkg.sv
package serial_bus_pkg;

   // ==========================================================================
   // Register indices (byte address is four times the index)
   // ==========================================================================
   localparam logic [7:0] CTRL_INDEX = 8'hc0;
   localparam logic [7:0] CFG_INDEX = 8'hc1;
   localparam logic [7:0] DATA_INDEX = 8'hc2;
   localparam logic [7:0] ACK_MODE_INDEX = 8'hc3;

   // ==========================================================================
   // Field positions
   // ==========================================================================
   localparam int CFG_ENABLE = 7;
   localparam int CFG_SLAVE_MASK = 6;
   localparam int CFG_BUSY = 5;
   localparam int CFG_EXTEND = 4;
   localparam int CFG_SCL_TOE = 3;
   localparam int CFG_FREE_TOE = 2;
   localparam int CTL_MASTER = 7;
   localparam int CTL_TX = 6;
   localparam int CTL_BEGIN = 5;
   localparam int CTL_HALT = 4;
   localparam int CTL_ACK_NEEDED = 3;
   localparam int CTL_ARB_LOSS = 2;
   localparam int CTL_ACK = 1;
   localparam int CTL_BYTE_EVENT = 0;
   localparam int ACK_MODE_AUTO = 0;

   // ==========================================================================
   // Reset values and timing counts: hold/setup in system clocks, free in source periods
   // ==========================================================================
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [3:0] HOLD_NORMAL = 4'h3;
   localparam logic [3:0] HOLD_EXTENDED = 4'hc;
   localparam logic [3:0] SETUP_NORMAL = 4'h1;
   localparam logic [3:0] SETUP_EXTENDED = 4'hb;
   localparam logic [3:0] FREE_PERIODS = 4'ha;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;

   localparam logic [1:0] SRC_TIMER0 = 2'h0;
   localparam logic [1:0] SRC_TIMER1 = 2'h1;
   localparam logic [1:0] SRC_TIMER2_HI = 2'h2;
   localparam logic [1:0] SRC_TIMER2_LO = 2'h3;

   typedef enum logic [2:0] {
      GEN_IDLE,
      GEN_START_A,
      GEN_START_B,
      GEN_START_C,
      GEN_BYTE,
      GEN_STOP_A,
      GEN_STOP_B
   } gen_t;

endpackage

// File: hw/smbus_config_and_control.sv
`timescale 1ns/1ns
// Operation
// - Enabled interface watches both lines continuously
// - Slave mask suppresses slave interrupts and slave ACKs
// - Busy set by transfer, cleared by stop/timeout
// - Extend bit selects normal or extended timing
// - Setup/hold counts: 11/12 extended, 3 hold
// - SCL-low timeout drives timer 3 reload
// - Free after eleven idle source periods high
// - Clock select picks one of four overflows
// - SCL low one period, high at least one
// - Upper control bits form a status vector
// - Begin flag reports start seen; halt flag a stop ending a slave transfer
// - Begin flag starts master when bus free
// - Halt flag stops after next acknowledge
// - Both flags give stop then start
// - Arbitration loss flagged, cleared with byte flag
// - Byte flag at start, end, byte, loss
// - Byte flag set holds SCL low
// - Interrupt placement around ACK by mode
// - Software ack: written or received ack bit
// - Ack needed on receive; default NACK
// - Ack write drives SDA at once
// - NACKed address ignores slave until start
// - Auto ack drives ack bit each byte
// - Hardware address NACK: no interrupt, ignore
// - Inhibit NACKs addresses from next start
module smbus_config_and_control
   import serial_bus_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic timer0_ovf,
   input wire logic timer1_ovf,
   input wire logic timer2_hi_ovf,
   input wire logic timer2_lo_ovf,
   input wire logic timer3_split,
   output logic timer3_reload_hi,
   output logic timer3_reload_lo,
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe
);

   // ==========================================================================
   // Decoding
   // ==========================================================================
   function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] index);
      byte_addr = ADDR_W'({index, 2'b00});
   endfunction

   function automatic logic pick_tick(input logic [1:0] sel, input logic [3:0] ovf);
      pick_tick = 1'b0;
      unique case (sel)
         SRC_TIMER0: pick_tick = ovf[0];
         SRC_TIMER1: pick_tick = ovf[1];
         SRC_TIMER2_HI: pick_tick = ovf[2];
         SRC_TIMER2_LO: pick_tick = ovf[3];
      endcase
   endfunction

   // ==========================================================================
   // Registers and state
   // ==========================================================================
   logic enable, slave_mask, busy, extend, scl_toe, free_toe;
   logic [1:0] clk_sel;
   logic master, transmitter_indicator, begin_flag, halt_flag, ack_needed, arb_loss, ack, byte_event;
   logic auto_ack;
   logic [7:0] shreg;
   logic [3:0] bit_cnt, hold_cnt, setup_cnt, free_cnt;
   logic [1:0] tcnt;
   logic slave_active, addr_phase, sda_last;
   logic [1:0] scl_sync, sda_sync;
   logic scl_q, sda_q;
   gen_t gen;

   logic scl_s, sda_s, tick, start_det, stop_det, scl_rise, scl_fall;
   logic frame_on, rise_bit, ack_phase, lost, early_rx, ack_done, addr_nack;
   logic ack_si, gen_start_done, gen_stop_done, slave_stop, si_set;
   logic hold_done, setup_ok, want_low, bus_free_to;
   logic apb_done, wr_ctl, wr_cfg, wr_dat, wr_mode, mapped;
   logic [7:0] read_val;

   // ==========================================================================
   // Line synchronisers and condition detection
   // ==========================================================================
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scl_sync <= 2'h3;
         sda_sync <= 2'h3;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else if (ce) begin
         scl_sync <= {scl_sync[0], scl_in};
         sda_sync <= {sda_sync[0], sda_in};
         scl_q <= scl_sync[1];
         sda_q <= sda_sync[1];
      end
   end

   assign scl_s = scl_sync[1];
   assign sda_s = sda_sync[1];
   // Monitoring only runs with the interface on
   assign start_det = enable && scl_q && scl_s && sda_q && !sda_s;
   assign stop_det = enable && scl_q && scl_s && !sda_q && sda_s;
   assign scl_rise = enable && !scl_q && scl_s;
   assign scl_fall = enable && scl_q && !scl_s;
   assign tick = pick_tick(clk_sel, {timer2_lo_ovf, timer2_hi_ovf, timer1_ovf, timer0_ovf});

   // ==========================================================================
   // Byte frame events
   // ==========================================================================
   assign frame_on = master ? (gen == GEN_BYTE) : slave_active;
   assign rise_bit = frame_on && scl_rise;
   assign ack_phase = bit_cnt == BITS_PER_BYTE;
   // Released SDA read back low while sending means another party won
   assign lost = rise_bit && !ack_phase && transmitter_indicator && !sda_oe && !sda_s;
   assign early_rx = rise_bit && bit_cnt == 4'h7 && !transmitter_indicator && !auto_ack && !lost;
   assign ack_done = rise_bit && ack_phase;
   assign addr_nack = ack_done && !master && addr_phase && !sda_oe;
   assign ack_si = ack_done && (transmitter_indicator || auto_ack) && !addr_nack;
   assign gen_start_done = gen == GEN_START_C && tick;
   assign gen_stop_done = gen == GEN_STOP_B && scl_s && tick;
   assign slave_stop = stop_det && slave_active && !master;
   // Slave events only fire while slave_active, which the mask blocks
   assign si_set = gen_start_done || early_rx || ack_si || lost || slave_stop;

   assign hold_done = hold_cnt == 4'h0 && !scl_s && !scl_q;
   // Release waits until SDA sits at its new level for the full setup count
   assign setup_ok = setup_cnt == 4'h0 && sda_oe == sda_last && sda_oe == want_low;
   assign bus_free_to = free_cnt > FREE_PERIODS;

   always_comb begin
      want_low = 1'b0;
      if (frame_on) begin
         if (ack_phase)
            want_low = !transmitter_indicator && ack;
         else
            want_low = transmitter_indicator && !byte_event && !shreg[7];
      end
   end

   // ==========================================================================
   // APB slave, one wait state
   // ==========================================================================
   assign apb_done = psel && penable && pready;
   assign mapped = paddr == byte_addr(CTRL_INDEX) || paddr == byte_addr(CFG_INDEX) ||
                   paddr == byte_addr(DATA_INDEX) || paddr == byte_addr(ACK_MODE_INDEX);
   assign wr_ctl = apb_done && pwrite && paddr == byte_addr(CTRL_INDEX);
   assign wr_cfg = apb_done && pwrite && paddr == byte_addr(CFG_INDEX);
   assign wr_dat = apb_done && pwrite && paddr == byte_addr(DATA_INDEX);
   assign wr_mode = apb_done && pwrite && paddr == byte_addr(ACK_MODE_INDEX);

   always_comb begin
      read_val = 8'h00;
      if (paddr == byte_addr(CTRL_INDEX))
         read_val = {master, transmitter_indicator, begin_flag, halt_flag,
                     ack_needed, arb_loss, ack, byte_event};
      else if (paddr == byte_addr(CFG_INDEX))
         read_val = {enable, slave_mask, busy, extend, scl_toe, free_toe, clk_sel};
      else if (paddr == byte_addr(DATA_INDEX))
         read_val = shreg;
      else if (paddr == byte_addr(ACK_MODE_INDEX))
         read_val = {7'h00, auto_ack};
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (ce) begin
         pready <= psel && penable && !pready;
         if (psel && penable && !pready) begin
            prdata <= {24'h00_0000, pwrite ? 8'h00 : read_val};
            pslverr <= !mapped;
         end
      end
   end

   // ==========================================================================
   // Configuration register
   // ==========================================================================
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {enable, slave_mask, extend, scl_toe, free_toe} <= 5'h00;
         clk_sel <= REG_RESET[1:0];
         auto_ack <= 1'b0;
      end else if (ce) begin
         if (wr_cfg) begin
            enable <= pwdata[CFG_ENABLE];
            slave_mask <= pwdata[CFG_SLAVE_MASK];
            extend <= pwdata[CFG_EXTEND];
            scl_toe <= pwdata[CFG_SCL_TOE];
            free_toe <= pwdata[CFG_FREE_TOE];
            clk_sel <= pwdata[1:0];
         end
         if (wr_mode)
            auto_ack <= pwdata[ACK_MODE_AUTO];
      end
   end

   // ==========================================================================
   // Busy tracking and free timeout
   // ==========================================================================
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         free_cnt <= 4'h0;
         busy <= 1'b0;
      end else if (ce) begin
         if (!(enable && free_toe && scl_s && sda_s))
            free_cnt <= 4'h0;
         else if (tick && !bus_free_to)
            free_cnt <= free_cnt + 4'h1;
         if (!enable || stop_det || bus_free_to)
            busy <= 1'b0;
         else if (start_det)
            busy <= 1'b1;
      end
   end

   // ==========================================================================
   // Timer 3 reload control
   // ==========================================================================
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer3_reload_hi <= 1'b0;
         timer3_reload_lo <= 1'b0;
      end else if (ce) begin
         timer3_reload_hi <= enable && scl_toe && scl_s;
         timer3_reload_lo <= enable && scl_toe && scl_s && !timer3_split;
      end
   end

   // ==========================================================================
   // Control and status flags; hardware sets win over software clears
   // ==========================================================================
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {master, transmitter_indicator, begin_flag, halt_flag} <= 4'h0;
         {ack_needed, arb_loss, ack, byte_event} <= 4'h0;
      end else if (ce) begin
         if (wr_ctl) begin
            begin_flag <= pwdata[CTL_BEGIN];
            halt_flag <= pwdata[CTL_HALT];
            ack <= pwdata[CTL_ACK];
            byte_event <= pwdata[CTL_BYTE_EVENT] || si_set;
            if (!pwdata[CTL_BYTE_EVENT]) begin
               arb_loss <= lost;
               ack_needed <= early_rx;
            end
         end else if (si_set) begin
            byte_event <= 1'b1;
         end
         if (lost) begin
            arb_loss <= 1'b1;
            master <= 1'b0;
            transmitter_indicator <= 1'b0;
         end
         if (early_rx) begin
            ack_needed <= 1'b1;
            ack <= 1'b0;
         end
         // Transmitter reads back the acknowledge it saw
         if (ack_done && transmitter_indicator)
            ack <= !sda_s;
         if (ack_done && addr_phase)
            transmitter_indicator <= master ? !shreg[0] : shreg[0];
         if (start_det) begin
            begin_flag <= 1'b1;
            if (gen == GEN_IDLE)
               transmitter_indicator <= 1'b0;
         end
         if (slave_stop)
            halt_flag <= 1'b1;
         if (gen_start_done) begin
            master <= 1'b1;
            transmitter_indicator <= 1'b1;
         end
         if (gen_stop_done) begin
            master <= 1'b0;
            halt_flag <= 1'b0;
         end
         if (!enable) begin
            master <= 1'b0;
            transmitter_indicator <= 1'b0;
         end
      end
   end

   // ==========================================================================
   // Shift register and frame tracking
   // ==========================================================================
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shreg <= REG_RESET;
         bit_cnt <= 4'h0;
         slave_active <= 1'b0;
         addr_phase <= 1'b0;
      end else if (ce) begin
         if (wr_dat)
            shreg <= pwdata[7:0];
         if (!enable) begin
            slave_active <= 1'b0;
            addr_phase <= 1'b0;
         end else if (start_det) begin
            bit_cnt <= 4'h0;
            addr_phase <= 1'b1;
            // Mask is sampled only here, so it acts from the next start
            slave_active <= gen == GEN_IDLE && !slave_mask;
         end else if (stop_det) begin
            slave_active <= 1'b0;
            addr_phase <= 1'b0;
         end else if (rise_bit) begin
            if (!ack_phase) begin
               shreg <= {shreg[6:0], sda_s};
               bit_cnt <= bit_cnt + 4'h1;
            end else begin
               bit_cnt <= 4'h0;
               addr_phase <= 1'b0;
            end
            if (lost || addr_nack)
               slave_active <= 1'b0;
         end
      end
   end

   // ==========================================================================
   // Hold and setup counters
   // ==========================================================================
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_cnt <= 4'h0;
         setup_cnt <= 4'h0;
         sda_last <= 1'b0;
      end else if (ce) begin
         sda_last <= sda_oe;
         if (scl_fall)
            hold_cnt <= extend ? HOLD_EXTENDED : HOLD_NORMAL;
         else if (hold_cnt != 4'h0)
            hold_cnt <= hold_cnt - 4'h1;
         if (sda_oe != sda_last)
            setup_cnt <= extend ? SETUP_EXTENDED : SETUP_NORMAL;
         else if (setup_cnt != 4'h0)
            setup_cnt <= setup_cnt - 4'h1;
      end
   end

   // ==========================================================================
   // Line drive and condition generation
   // ==========================================================================
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gen <= GEN_IDLE;
         scl_oe <= 1'b0;
         sda_oe <= 1'b0;
         scl_out <= 1'b0;
         sda_out <= 1'b0;
         tcnt <= 2'h0;
      end else if (ce) begin
         scl_out <= 1'b0;
         sda_out <= 1'b0;
         if (!enable || lost) begin
            gen <= GEN_IDLE;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
         end else begin
            unique case (gen)
               GEN_IDLE: begin
                  // Slave keeps SCL low while its byte flag stands
                  scl_oe <= byte_event && slave_active && (scl_oe || !scl_s);
                  if (slave_active && hold_done)
                     sda_oe <= want_low;
                  else if (!slave_active)
                     sda_oe <= 1'b0;
                  if (begin_flag && !busy && !slave_active)
                     gen <= GEN_START_A;
               end
               GEN_START_A: begin
                  sda_oe <= 1'b0;
                  if (sda_s && tick) begin
                     scl_oe <= 1'b0;
                     gen <= GEN_START_B;
                  end
               end
               GEN_START_B: begin
                  if (scl_s && sda_s && tick) begin
                     sda_oe <= 1'b1;
                     gen <= GEN_START_C;
                  end
               end
               GEN_START_C: begin
                  if (tick) begin
                     scl_oe <= 1'b1;
                     tcnt <= 2'h0;
                     gen <= GEN_BYTE;
                  end
               end
               GEN_BYTE: begin
                  if (scl_oe) begin
                     if (hold_done)
                        sda_oe <= want_low;
                     if (tick && tcnt != 2'h3)
                        tcnt <= tcnt + 2'h1;
                     if (!byte_event && bit_cnt == 4'h0 && hold_done && halt_flag) begin
                        gen <= GEN_STOP_A;
                     end else if (!byte_event && bit_cnt == 4'h0 && hold_done && begin_flag) begin
                        gen <= GEN_START_A;
                     end else if (tcnt != 2'h0 && setup_ok && hold_done && !byte_event) begin
                        // Low phase ends a full source period after it began
                        scl_oe <= 1'b0;
                        tcnt <= 2'h0;
                     end
                  end else if (scl_s && tick) begin
                     // High counted only once SCL is seen high, so stretching holds it
                     if (tcnt == 2'h1) begin
                        scl_oe <= 1'b1;
                        tcnt <= 2'h0;
                     end else begin
                        tcnt <= tcnt + 2'h1;
                     end
                  end
               end
               GEN_STOP_A: begin
                  sda_oe <= 1'b1;
                  if (tick && hold_done && sda_oe) begin
                     scl_oe <= 1'b0;
                     gen <= GEN_STOP_B;
                  end
               end
               GEN_STOP_B: begin
                  if (scl_s && tick) begin
                     sda_oe <= 1'b0;
                     gen <= begin_flag ? GEN_START_A : GEN_IDLE;
                  end
               end
            endcase
         end
      end
   end

endmodule

// File: sim/serial_bus_monitor.sv
`timescale 1ns/1ns
module serial_bus_monitor #(
   parameter int ADDR_W = 12
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic timer3_split,
   input wire logic timer3_reload_hi,
   input wire logic timer3_reload_lo,
   input wire logic scl_in,
   input wire logic scl_out,
   input wire logic scl_oe,
   input wire logic sda_out,
   input wire logic sda_oe
);
   // ==========================================================
   // Bus and pin properties
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic mapped;
   assign mapped = paddr inside {12'h300, 12'h304, 12'h308, 12'h30c};
   sequence s_first_access;
      psel && penable && !$past(penable);
   endsequence
   sequence s_scl_pull;
      $rose(scl_oe);
   endsequence
   property p_ready_wait;
      s_first_access |-> !pready ##1 pready;
   endproperty
   property p_ready_pulse;
      pready |=> !pready;
   endproperty
   property p_unmapped;
      pready && !mapped |-> pslverr && (pwrite || prdata == 32'h0);
   endproperty
   property p_mapped;
      pready && mapped |-> !pslverr && prdata[31:8] == 24'h0;
   endproperty
   property p_open_drain;
      !scl_out && !sda_out;
   endproperty
   property p_reload_split;
      timer3_reload_lo |-> timer3_reload_hi && !$past(timer3_split);
   endproperty
   property p_reload_low;
      !scl_in [*4] |-> !timer3_reload_hi;
   endproperty
   property p_hold;
      s_scl_pull |=> $stable(sda_oe) [*3];
   endproperty
   property p_setup;
      $fell(scl_oe) |-> $stable(sda_oe);
   endproperty
   property p_stall;
      pready && !pwrite && paddr == 12'h300 && prdata[0] |-> ##[0:24] scl_oe;
   endproperty
   property p_reset_quiet;
      $rose(presetn) |-> !pready && !scl_oe && !sda_oe;
   endproperty
   a_ready_wait: assert property (p_ready_wait) else $error("late pready");
   a_ready_pulse: assert property (p_ready_pulse) else $error("long pready");
   a_unmapped: assert property (p_unmapped) else $error("no error on hole");
   a_mapped: assert property (p_mapped) else $error("bad mapped answer");
   a_open_drain: assert property (p_open_drain) else $error("pin driven high");
   a_reload_split: assert property (p_reload_split) else $error("low reload");
   a_reload_low: assert property (p_reload_low) else $error("reload at low");
   a_hold: assert property (p_hold) else $error("hold short");
   a_setup: assert property (p_setup) else $error("setup short");
   a_stall: assert property (p_stall) else $error("stall lost");
   a_reset_quiet: assert property (p_reset_quiet) else $error("busy after reset");
endmodule
bind smbus_config_and_control serial_bus_monitor #(.ADDR_W(ADDR_W)) i_serial_bus_monitor (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .timer3_split(timer3_split), .timer3_reload_hi(timer3_reload_hi),
   .timer3_reload_lo(timer3_reload_lo), .scl_in(scl_in), .scl_out(scl_out),
   .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe));

// File: sim/bus_slave_model.sv
`timescale 1ns/1ns
// ==========================================================
// Slave that acknowledges the address byte on request
module bus_slave_model (
   input wire logic pclk,
   input wire logic scl,
   input wire logic sda,
   input wire logic ack_en,
   output logic sda_pull
);
   logic scl_d = 1'b1;
   logic sda_d = 1'b1;
   logic [4:0] falls = 5'h1f;
   initial sda_pull = 1'b0;
   always @(posedge pclk) begin
      scl_d <= scl;
      sda_d <= sda;
      if (scl && sda_d && !sda) begin
         falls <= 5'h0;
      end else if (scl_d && !scl) begin
         falls <= falls + 5'h1;
         // Ninth clock belongs to the receiver
         sda_pull <= ack_en && falls == 5'h8;
      end
   end
endmodule

// File: sim/smbus_config_and_control_bench.sv
`timescale 1ns/1ns
module smbus_config_and_control_bench;
   import serial_bus_pkg::*;
   typedef struct packed {logic w; logic [11:0] a; logic [7:0] d; logic [7:0] x; logic e;} row_t;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, split = 0, ack_en = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata;
   logic pready, pslverr, scl_oe, sda_oe, pull, scl_d = 1, e, rl_hi, rl_lo;
   logic [3:0] tmr = 0, mask = 0;
   logic [2:0] tc = 0;
   logic [7:0] r;
   logic [8:0] sh = 0;
   int errors = 0, comparisons = 0;
   wire scl = !scl_oe;
   wire sda = !(sda_oe | pull);
   row_t rows [12] = '{'{0, 12'h304, 0, 8'h00, 0}, '{0, 12'h300, 0, 8'h00, 0},
      '{1, 12'h304, 8'hff, 0, 0}, '{0, 12'h304, 0, 8'hdf, 0}, '{1, 12'h304, 0, 0, 0},
      '{1, 12'h300, 8'hcc, 0, 0}, '{0, 12'h300, 0, 8'h00, 0}, '{1, 12'h30c, 8'h01, 0, 0},
      '{0, 12'h30c, 0, 8'h01, 0}, '{1, 12'h30c, 0, 0, 0}, '{1, 12'h3f0, 8'h55, 0, 1},
      '{0, 12'h3f0, 0, 8'h00, 1}};
   always #10 pclk = ~pclk;
   // Overflow pulses every 160 ns; wire bits captured on SCL rise
   always @(posedge pclk) begin
      tc <= tc + 3'h1;
      tmr <= (tc == 3'h7) ? mask : 4'h0;
      scl_d <= scl;
      if (scl && !scl_d) sh <= {sh[7:0], sda};
   end
   smbus_config_and_control #(.ADDR_W(12)) i_smbus_config_and_control (.pclk(pclk),
      .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .timer0_ovf(tmr[0]), .timer1_ovf(tmr[1]), .timer2_hi_ovf(tmr[2]),
      .timer2_lo_ovf(tmr[3]), .timer3_split(split), .timer3_reload_hi(rl_hi),
      .timer3_reload_lo(rl_lo), .scl_in(scl), .scl_out(), .scl_oe(scl_oe), .sda_in(sda),
      .sda_out(), .sda_oe(sda_oe));
   bus_slave_model i_bus_slave_model (.pclk(pclk), .scl(scl), .sda(sda), .ack_en(ack_en),
      .sda_pull(pull));
   task give_verdict();
      $display("errors=%0d comparisons=%0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task check(input logic [8:0] seen, input logic [8:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // Request held until pready seen high at a rising edge
   task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      int n;
      n = 0;
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk) penable <= 1;
      do begin
         @(posedge pclk) n++;
      end while (pready !== 1'b1 && n < 20);
      r = prdata[7:0];
      e = pslverr;
      if (pready !== 1'b1) begin
         errors++;
         give_verdict();
      end
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
   endtask
   task poll(input logic [11:0] a, input int b, input logic v);
      int n;
      n = 0;
      apb(0, a, 0);
      while (r[b] !== v && n < 400) begin
         apb(0, a, 0);
         n++;
      end
      if (n == 400) begin
         errors++;
         give_verdict();
      end
   endtask
   task xfer(input logic [1:0] cs);
      mask <= 4'h1 << cs;
      ack_en <= cs[0];
      split <= cs == 2'h2;
      apb(1, 12'h304, {3'h4, cs[1], 2'h3, cs});
      apb(1, 12'h300, 8'h20);
      poll(12'h300, 0, 1);
      check(r, 8'he1);
      apb(0, 12'h304, 0);
      check(r[5], 1'b1);
      check({rl_hi, rl_lo}, 2'h0);
      apb(1, 12'h308, 8'ha4);
      apb(1, 12'h300, 8'h00);
      poll(12'h300, 0, 1);
      check(r, {6'h30, cs[0], 1'b1});
      check(sh, {8'ha4, !cs[0]});
      apb(1, 12'h300, 8'h10);
      poll(12'h304, 5, 0);
      apb(0, 12'h300, 0);
      check({r[7], r[4]}, 2'h0);
      check({rl_hi, rl_lo}, {1'b1, !split});
      apb(1, 12'h304, 0);
   endtask
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      foreach (rows[i]) begin
         apb(rows[i].w, rows[i].a, rows[i].d);
         check(e, rows[i].e);
         if (!rows[i].w) check(r, rows[i].x);
      end
      // Every clock source, both ack answers, both timings
      for (int i = 0; i < 4; i++) xfer(i[1:0]);
      // Second reset in mid-run restores the config register
      apb(1, 12'h304, 8'h90);
      presetn <= 0;
      repeat (3) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      apb(0, 12'h304, 0);
      check(r, 8'h00);
      give_verdict();
   end
   initial begin
      repeat (90000) @(posedge pclk);
      errors++;
      give_verdict();
   end
endmodule
